// file: design/msp_pkg.sv
/*
 * Shared constants and carrier types of the memory switch partition block:
 * register offsets, field positions, reset values and the partition table.
 * Assumes a 24-bit core with program, X and Y address buses.
 */
package msp_pkg;

    // ---------------------------------------------------------------
    // Bus widths
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W     = 24;
    localparam int unsigned DATA_W     = 24;
    localparam int unsigned REG_AW     = 8;
    localparam int unsigned REG_DW     = 32;
    localparam int unsigned EXT_W      = 18;
    localparam int unsigned KW_SHIFT   = 10;
    localparam int unsigned KW_W       = 6;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0]  CFG_OFS    = 8'h00;
    localparam logic [7:0]  SIZE_OFS   = 8'h04;
    localparam logic [7:0]  FAULT_OFS  = 8'h08;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int unsigned CFG_CE_BIT   = 0;
    localparam int unsigned CFG_MS_BIT   = 1;
    localparam int unsigned CFG_SLO_BIT  = 2;
    localparam int unsigned CFG_SHI_BIT  = 3;
    localparam logic [3:0]  CFG_RST      = 4'h0;
    localparam int unsigned SIZE_P_LSB   = 0;
    localparam int unsigned SIZE_XY_LSB  = 8;
    localparam int unsigned SIZE_C_LSB   = 16;
    localparam logic [2:0]  FAULT_RST    = 3'h0;

    // ---------------------------------------------------------------
    // Partition table, in K words
    // ---------------------------------------------------------------
    localparam logic [5:0]  P_KW_FLAT    = 6'h10;
    localparam logic [5:0]  XY_KW_FLAT   = 6'h18;
    localparam logic [5:0]  P_KW_SW_MAX  = 6'h30;
    localparam logic [5:0]  XY_KW_SW_MIN = 6'h08;
    localparam logic [5:0]  P_KW_STEP    = 6'h08;
    localparam logic [5:0]  XY_KW_STEP   = 6'h04;
    localparam logic [5:0]  CACHE_KW     = 6'h01;
    localparam logic [5:0]  SHARED_KW    = 6'h04;

    // ---------------------------------------------------------------
    // Bootstrap ROM placement in program space
    // ---------------------------------------------------------------
    localparam logic [23:0] BOOT_BASE    = 24'hFF0000;
    localparam int unsigned BOOT_WORDS   = 192;

    // Decoded destination of one access
    typedef struct packed {
        logic              valid;
        logic              to_int;
        logic              to_ext;
        logic              to_boot;
        logic              shared;
        logic              fault;
        logic [EXT_W-1:0]  offs;
    } msp_route_t;

    // Live partition
    typedef struct packed {
        logic       cache_en;
        logic [5:0] p_kw;
        logic [5:0] xy_kw;
    } msp_part_t;

endpackage

// file: design/msp_switch.sv
/*
 * Memory switch partition: sizes program RAM, instruction cache and the
 * X and Y data RAM from a software configuration word, and routes every
 * program, X and Y access to internal RAM, boot ROM or the expansion port, or flags it as a fault.
 * Assumes one clock, address requests synchronous to it, and a register
 * master that never expects a wait.
 */

// ---------------------------------------------------------------
// One address space decoder
// ---------------------------------------------------------------
module msp_space_dec
#(
    parameter bit HAS_BOOT   = 1'b0,
    parameter bit HAS_SHARED = 1'b0
)
(
    // Request
    input  wire logic                     req_i,
    input  wire logic [msp_pkg::ADDR_W-1:0] addr_i,
    // Live size
    input  wire logic [5:0]               size_kw_i,
    // Decision
    output msp_pkg::msp_route_t           route_o
);

    logic [msp_pkg::ADDR_W-1:0] int_words;
    logic [msp_pkg::ADDR_W-1:0] shr_start;
    logic [msp_pkg::ADDR_W-1:0] boot_end;
    logic                       in_boot;
    logic                       in_int;
    logic                       in_ext;

    assign int_words = {8'h00, size_kw_i, 10'h000};
    assign shr_start = int_words - {8'h00, msp_pkg::SHARED_KW, 10'h000};
    assign boot_end  = msp_pkg::BOOT_BASE
                     + 24'(msp_pkg::BOOT_WORDS);
    assign in_boot   = HAS_BOOT && addr_i >= msp_pkg::BOOT_BASE
                     && addr_i < boot_end;
    assign in_int    = addr_i < int_words;
    assign in_ext    = addr_i[msp_pkg::ADDR_W-1:msp_pkg::EXT_W] == '0;

    always_comb
    begin
        route_o         = '0;
        route_o.valid   = req_i;
        route_o.offs    = addr_i[msp_pkg::EXT_W-1:0];
        if (!req_i)
        begin
            route_o.offs = '0;
        end
        else if (in_boot)
        begin
            route_o.to_boot = 1'b1;
            route_o.offs    = 18'(addr_i - msp_pkg::BOOT_BASE);
        end
        else if (in_int)
        begin
            route_o.to_int  = 1'b1;
            route_o.shared  = HAS_SHARED && addr_i >= shr_start;
        end
        else if (in_ext)
        begin
            route_o.to_ext  = 1'b1;
        end
        else
        begin
            route_o.fault   = 1'b1;
        end
    end

endmodule

module msp_switch
#(
    parameter int unsigned ADDR_W     = msp_pkg::ADDR_W,
    parameter int unsigned BOOT_WORDS = msp_pkg::BOOT_WORDS,
    parameter logic [BOOT_WORDS*msp_pkg::DATA_W-1:0] BOOT_IMAGE = '0
)
(
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Register port
    input  wire logic [msp_pkg::REG_AW-1:0]  reg_addr_i,
    input  wire logic [msp_pkg::REG_DW-1:0]  reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [msp_pkg::REG_DW-1:0]  reg_rdata_o,
    // Core address buses
    input  wire logic                        p_req_i,
    input  wire logic [ADDR_W-1:0]           p_addr_i,
    input  wire logic                        x_req_i,
    input  wire logic [ADDR_W-1:0]           x_addr_i,
    input  wire logic                        y_req_i,
    input  wire logic [ADDR_W-1:0]           y_addr_i,
    // Routing decisions
    output msp_pkg::msp_route_t              p_route_o,
    output msp_pkg::msp_route_t              x_route_o,
    output msp_pkg::msp_route_t              y_route_o,
    output logic      [msp_pkg::DATA_W-1:0]  boot_data_o,
    // Live partition
    output msp_pkg::msp_part_t               part_o
);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    if (ADDR_W != msp_pkg::ADDR_W)
    begin : g_chk_aw
        $error("address width must be 24");
    end
    if (BOOT_WORDS == 0 || BOOT_WORDS > msp_pkg::BOOT_WORDS)
    begin : g_chk_boot
        $error("boot ROM depth out of range");
    end

    // ---------------------------------------------------------------
    // Configuration register
    // ---------------------------------------------------------------
    logic [3:0]  cfg_r;
    logic        wr_cfg;
    logic        wr_fault;
    logic        rd_hit;

    assign wr_cfg   = reg_wr_i && reg_addr_i == msp_pkg::CFG_OFS;
    assign wr_fault = reg_wr_i && reg_addr_i == msp_pkg::FAULT_OFS;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_r <= msp_pkg::CFG_RST;
        end
        else if (wr_cfg)
        begin
            cfg_r <= reg_wdata_i[3:0];
        end
    end

    // ---------------------------------------------------------------
    // Partition decode
    // ---------------------------------------------------------------
    logic       cache_en;
    logic       switch_mode;
    logic [1:0] switch_sel;
    logic [5:0] p_kw;
    logic [5:0] xy_kw;
    logic [5:0] p_ram_kw;

    assign cache_en    = cfg_r[msp_pkg::CFG_CE_BIT];
    assign switch_mode = cfg_r[msp_pkg::CFG_MS_BIT];
    assign switch_sel  = {cfg_r[msp_pkg::CFG_SHI_BIT],
                          cfg_r[msp_pkg::CFG_SLO_BIT]};

    always_comb
    begin
        if (!switch_mode)
        begin
            p_kw  = msp_pkg::P_KW_FLAT;
            xy_kw = msp_pkg::XY_KW_FLAT;
        end
        else
        begin
            unique case (switch_sel)
                2'h0:
                begin
                    p_kw  = msp_pkg::P_KW_SW_MAX;
                    xy_kw = msp_pkg::XY_KW_SW_MIN;
                end
                2'h1:
                begin
                    p_kw  = msp_pkg::P_KW_SW_MAX
                          - msp_pkg::P_KW_STEP;
                    xy_kw = msp_pkg::XY_KW_SW_MIN
                          + msp_pkg::XY_KW_STEP;
                end
                2'h2:
                begin
                    p_kw  = msp_pkg::P_KW_SW_MAX
                          - 6'(2 * msp_pkg::P_KW_STEP);
                    xy_kw = msp_pkg::XY_KW_SW_MIN
                          + 6'(2 * msp_pkg::XY_KW_STEP);
                end
                2'h3:
                begin
                    p_kw  = msp_pkg::P_KW_SW_MAX
                          - 6'(3 * msp_pkg::P_KW_STEP);
                    xy_kw = msp_pkg::XY_KW_SW_MIN
                          + 6'(3 * msp_pkg::XY_KW_STEP);
                end
            endcase
        end
    end

    // Cache carves its words out of program RAM only
    assign p_ram_kw = cache_en ? p_kw - msp_pkg::CACHE_KW : p_kw;

    // ---------------------------------------------------------------
    // Per-space decoders
    // ---------------------------------------------------------------
    msp_pkg::msp_route_t p_dec;
    msp_pkg::msp_route_t x_dec;
    msp_pkg::msp_route_t y_dec;

    msp_space_dec #(.HAS_BOOT(1'b1), .HAS_SHARED(1'b0)) u_p_dec
    (
        .req_i     (p_req_i),
        .addr_i    (p_addr_i),
        .size_kw_i (p_ram_kw),
        .route_o   (p_dec)
    );

    msp_space_dec #(.HAS_BOOT(1'b0), .HAS_SHARED(1'b1)) u_x_dec
    (
        .req_i     (x_req_i),
        .addr_i    (x_addr_i),
        .size_kw_i (xy_kw),
        .route_o   (x_dec)
    );

    msp_space_dec #(.HAS_BOOT(1'b0), .HAS_SHARED(1'b1)) u_y_dec
    (
        .req_i     (y_req_i),
        .addr_i    (y_addr_i),
        .size_kw_i (xy_kw),
        .route_o   (y_dec)
    );

    // ---------------------------------------------------------------
    // Registered routing outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            p_route_o <= '0;
            x_route_o <= '0;
            y_route_o <= '0;
        end
        else
        begin
            p_route_o <= p_dec;
            x_route_o <= x_dec;
            y_route_o <= y_dec;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            part_o <= '0;
        end
        else
        begin
            part_o.cache_en <= cache_en;
            part_o.p_kw     <= p_ram_kw;
            part_o.xy_kw    <= xy_kw;
        end
    end

    // ---------------------------------------------------------------
    // Bootstrap ROM
    // ---------------------------------------------------------------
    logic [7:0] boot_idx;

    assign boot_idx = p_dec.offs[7:0];

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            boot_data_o <= '0;
        end
        else if (p_dec.to_boot)
        begin
            boot_data_o <= BOOT_IMAGE[boot_idx*msp_pkg::DATA_W +:
                                      msp_pkg::DATA_W];
        end
        else
        begin
            boot_data_o <= '0;
        end
    end

    // ---------------------------------------------------------------
    // Sticky fault flags, write one to clear, set wins
    // ---------------------------------------------------------------
    logic [2:0] fault_r;
    logic [2:0] fault_set;
    logic [2:0] fault_nxt;

    assign fault_set = {y_dec.fault, x_dec.fault, p_dec.fault};

    always_comb
    begin
        fault_nxt = fault_r;
        if (wr_fault)
        begin
            fault_nxt = fault_r & ~reg_wdata_i[2:0];
        end
        fault_nxt = fault_nxt | fault_set;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fault_r <= msp_pkg::FAULT_RST;
        end
        else
        begin
            fault_r <= fault_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Register read port
    // ---------------------------------------------------------------
    logic [msp_pkg::REG_DW-1:0] rd_nxt;

    assign rd_hit = reg_rd_i;

    always_comb
    begin
        rd_nxt = '0;
        unique case (reg_addr_i)
            msp_pkg::CFG_OFS:
            begin
                rd_nxt[3:0] = cfg_r;
            end
            msp_pkg::SIZE_OFS:
            begin
                rd_nxt[msp_pkg::SIZE_P_LSB +: 6]  = p_ram_kw;
                rd_nxt[msp_pkg::SIZE_XY_LSB +: 6] = xy_kw;
                rd_nxt[msp_pkg::SIZE_C_LSB]       = cache_en;
            end
            msp_pkg::FAULT_OFS:
            begin
                rd_nxt[2:0] = fault_r;
            end
            default:
            begin
                rd_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= '0;
        end
        else if (rd_hit)
        begin
            reg_rdata_o <= rd_nxt;
        end
        else
        begin
            reg_rdata_o <= '0;
        end
    end

endmodule

// file: bench/msp_core_model.sv
/*
 * Core model: drives the program, X and Y address buses.
 * Assumes the bench hands it one request set per clock.
 */
module msp_core_model
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Request from the bench
    input  wire logic        go_i,
    input  wire logic [23:0] ap_i,
    input  wire logic [23:0] ax_i,
    input  wire logic [23:0] ay_i,
    // Core buses
    output logic             p_req_o,
    output logic [23:0]      p_addr_o,
    output logic             x_req_o,
    output logic [23:0]      x_addr_o,
    output logic             y_req_o,
    output logic [23:0]      y_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Three buses together; idle address toggles
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {p_req_o, x_req_o, y_req_o} <= 3'h0;
            {p_addr_o, x_addr_o, y_addr_o} <= 72'h0;
        end
        else
        begin
            {p_req_o, x_req_o, y_req_o} <= {3{go_i}};
            p_addr_o <= go_i ? ap_i : ~p_addr_o;
            x_addr_o <= go_i ? ax_i : ~x_addr_o;
            y_addr_o <= go_i ? ay_i : ~y_addr_o;
        end
    end
endmodule

// file: bench/msp_switch_monitor.sv
/*
 * Checker on the ports of msp_switch.
 * Assumes one clock domain; bound at the foot.
 */
module msp_switch_monitor
#(
    parameter int unsigned ADDR_W = 24
)
(
    // Clock and reset
    input wire logic                clk_i,
    input wire logic                rst_i,
    // Core requests
    input wire logic                p_req_i,
    input wire logic [ADDR_W-1:0]   p_addr_i,
    input wire logic                x_req_i,
    input wire logic [ADDR_W-1:0]   x_addr_i,
    input wire logic                y_req_i,
    input wire logic [ADDR_W-1:0]   y_addr_i,
    // Decisions
    input wire msp_pkg::msp_route_t p_route_o,
    input wire msp_pkg::msp_route_t x_route_o,
    input wire msp_pkg::msp_route_t y_route_o,
    input wire msp_pkg::msp_part_t  part_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [23:0] p_top;
    logic [23:0] xy_top;

    assign p_top = {8'h00, part_o.p_kw, 10'h000};
    assign xy_top = {8'h00, part_o.xy_kw, 10'h000};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ----------
    // Steps
    // ----------
    sequence s_x_ext;
        x_req_i && x_addr_i >= xy_top && x_addr_i < 24'h040000;
    endsequence
    sequence s_y_shr;
        y_req_i && y_addr_i < xy_top && y_addr_i >= xy_top - 24'h001000;
    endsequence

    // ----------
    // Rules
    // ----------
    property p_quiet;
        !p_req_i && !x_req_i && !y_req_i |=>
            p_route_o == '0 && x_route_o == '0 && y_route_o == '0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("idle route");
    property p_all;
        p_req_i && x_req_i && y_req_i |=>
            p_route_o.valid && x_route_o.valid && y_route_o.valid;
    endproperty
    a_all: assert property (p_all) else $error("missing route");
    property p_sum;
        part_o.xy_kw != '0 |-> 7'(part_o.p_kw) + 7'(part_o.cache_en)
            + {part_o.xy_kw, 1'h0} == 7'h40;
    endproperty
    a_sum: assert property (p_sum) else $error("bad split");
    property p_x_ext;
        s_x_ext ##1 $stable(part_o) |-> x_route_o.to_ext;
    endproperty
    a_x_ext: assert property (p_x_ext) else $error("x not ext");
    property p_p_ext;
        p_req_i && p_addr_i >= p_top && p_addr_i < 24'h040000
            ##1 $stable(part_o) |-> p_route_o.to_ext;
    endproperty
    a_p_ext: assert property (p_p_ext) else $error("p not ext");
    property p_y_shr;
        s_y_shr ##1 $stable(part_o) |-> y_route_o.shared && y_route_o.to_int;
    endproperty
    a_y_shr: assert property (p_y_shr) else $error("y not shared");
    property p_fault;
        x_req_i && x_addr_i >= 24'h040000 |=>
            x_route_o.fault && !x_route_o.to_ext && !x_route_o.to_int;
    endproperty
    a_fault: assert property (p_fault) else $error("x no fault");
    property p_boot;
        p_req_i && p_addr_i >= 24'hFF0000 && p_addr_i <= 24'hFF00BF |=>
            p_route_o.to_boot
            && p_route_o.offs == 18'($past(p_addr_i) - 24'hFF0000);
    endproperty
    a_boot: assert property (p_boot) else $error("boot miss");
    property p_offs;
        x_req_i |=> x_route_o.offs == 18'($past(x_addr_i));
    endproperty
    a_offs: assert property (p_offs) else $error("bad offset");
endmodule

bind msp_switch msp_switch_monitor #(.ADDR_W(ADDR_W)) u_mon
(
    .clk_i(clk_i), .rst_i(rst_i), .part_o(part_o),
    .p_req_i(p_req_i), .p_addr_i(p_addr_i), .p_route_o(p_route_o),
    .x_req_i(x_req_i), .x_addr_i(x_addr_i), .x_route_o(x_route_o),
    .y_req_i(y_req_i), .y_addr_i(y_addr_i), .y_route_o(y_route_o)
);

// file: bench/tb.sv
/*
 * Self-checking bench of msp_switch with a core model in front.
 * Assumes the checker binds itself from its own file.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BW = msp_pkg::BOOT_WORDS;

    function automatic logic [BW*24-1:0] mk();
        for (int i = 0; i < BW; i++)
        begin
            mk[i*24 +: 24] = 24'(i * 7) ^ 24'h5A3C96;
        end
    endfunction
    localparam logic [BW*24-1:0] IMG = mk();

    logic                clk_i = 1'h0;
    logic                rst_i = 1'h1;
    logic [7:0]          reg_addr_i = 8'h00;
    logic [31:0]         reg_wdata_i = 32'h0;
    logic                reg_wr_i = 1'h0;
    logic                reg_rd_i = 1'h0;
    logic [31:0]         reg_rdata_o;
    logic                cgo = 1'h0;
    logic [23:0]         cp = 24'h0, cx = 24'h0, cy = 24'h0, pt, xt;
    logic                p_req, x_req, y_req, ce = 1'h0, rd_seen = 1'h0;
    logic [23:0]         p_addr, x_addr, y_addr, boot_d, pl[8], xl[8];
    msp_pkg::msp_route_t p_rt, x_rt, y_rt;
    msp_pkg::msp_part_t  part;
    logic [5:0]          pk = 6'h10, xk = 6'h18;
    logic [31:0]         eq[$], rq[$], bq[$];
    int                  checks = 0, miscompares = 0;

    always #4 clk_i = ~clk_i;

    msp_core_model core
    (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(cgo),
        .ap_i(cp), .ax_i(cx), .ay_i(cy),
        .p_req_o(p_req), .p_addr_o(p_addr), .x_req_o(x_req),
        .x_addr_o(x_addr), .y_req_o(y_req), .y_addr_o(y_addr)
    );
    msp_switch #(.BOOT_IMAGE(IMG)) uut
    (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .p_req_i(p_req), .p_addr_i(p_addr), .x_req_i(x_req),
        .x_addr_i(x_addr), .y_req_i(y_req), .y_addr_i(y_addr),
        .p_route_o(p_rt), .x_route_o(x_rt), .y_route_o(y_rt),
        .boot_data_o(boot_d), .part_o(part)
    );

    // ----------
    // Helpers
    // ----------
    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] nx(ref logic [31:0] q[$]);
        return q.size() ? q.pop_front() : 32'hFFFFFFFF;
    endfunction
    function automatic logic [31:0] sz();
        return {15'h0, ce, 2'h0, xk, 2'h0, pk};
    endfunction
    function automatic msp_pkg::msp_route_t ex(input int s, logic [23:0] a);
        msp_pkg::msp_route_t r;
        logic [23:0] t;
        r = '0;
        t = {8'h00, (s == 0) ? pk : xk, 10'h000};
        r.valid = 1'h1;
        r.offs = a[17:0];
        if (s == 0 && a >= 24'hFF0000 && a < 24'hFF00C0)
        begin
            r.to_boot = 1'h1;
            r.offs = 18'(a - 24'hFF0000);
        end
        else if (a < t)
        begin
            r.to_int = 1'h1;
            r.shared = s != 0 && a >= t - 24'h001000;
        end
        else if (a < 24'h040000) r.to_ext = 1'h1;
        else r.fault = 1'h1;
        return r;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        rq.push_back(e);
        @(posedge clk_i);
        reg_rd_i <= 1'h0;
    endtask
    task automatic setc(input logic [3:0] c);
        wr(8'h00, {28'h0, c});
        ce = c[0];
        xk = c[1] ? 6'h08 + {2'h0, c[3:2], 2'h0} : 6'h18;
        pk = (c[1] ? 6'h30 - {1'h0, c[3:2], 3'h0} : 6'h10) - {5'h00, c[0]};
    endtask
    task automatic go(input logic [23:0] ap, ax, ay);
        @(posedge clk_i);
        cgo <= 1'h1;
        cp <= ap;
        cx <= ax;
        cy <= ay;
        eq.push_back(32'(ex(0, ap)));
        eq.push_back(32'(ex(1, ax)));
        eq.push_back(32'(ex(2, ay)));
        if (ap >= 24'hFF0000 && ap < 24'hFF00C0)
            bq.push_back({8'h00, IMG[(ap - 24'hFF0000) * 24 +: 24]});
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------
    // Result watcher
    // ----------
    always @(negedge clk_i)
    begin
        if (rd_seen) chk("rdata", nx(rq), reg_rdata_o);
        rd_seen = reg_rd_i;
        if (p_rt.valid === 1'h1) chk("p", nx(eq), 32'(p_rt));
        if (x_rt.valid === 1'h1) chk("x", nx(eq), 32'(x_rt));
        if (y_rt.valid === 1'h1) chk("y", nx(eq), 32'(y_rt));
        if (p_rt.to_boot === 1'h1) chk("boot", nx(bq), 32'(boot_d));
    end

    // ----------
    // Tests
    // ----------
    initial
    begin
        void'($urandom(69));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        @(negedge clk_i);
        chk("part", {19'h0, 1'h0, pk, xk}, 32'(part));
        rd(8'h00, 32'h0);
        rd(8'h04, sz());
        rd(8'h08, 32'h0);
        for (int c = 0; c < 16; c++)
        begin
            setc(4'(c));
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk("part", {19'h0, ce, pk, xk}, 32'(part));
            rd(8'h04, sz());
            pt = {8'h00, pk, 10'h000};
            xt = {8'h00, xk, 10'h000};
            pl = '{pt - 24'h1, pt, 24'h03FFFF, 24'h040000, 24'hFF0000,
                   24'hFF00BF, 24'hFF00C0, 24'($urandom)};
            xl = '{xt - 24'h1, xt, xt - 24'h1000, xt - 24'h1001,
                   24'h03FFFF, 24'h040000, 24'hFFFFFF,
                   24'($urandom_range(0, 32'h3FFFF))};
            for (int i = 0; i < 8; i++) go(pl[i], xl[i], xl[7 - i]);
            @(posedge clk_i);
            cgo <= 1'h0;
        end
        rd(8'h08, 32'h7);
        wr(8'h08, 32'h1);
        rd(8'h08, 32'h6);
        wr(8'h08, 32'h6);
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h0);
        rd(8'h04, sz());
        wr(8'h0C, 32'hF);
        rd(8'h0C, 32'h0);
        rd(8'h00, 32'hF);
        repeat (3) @(posedge clk_i);
        chk("left", 32'h0, 32'(eq.size() + rq.size() + bq.size()));
        conclude();
    end

    // Hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #50000;
        miscompares++;
        conclude();
    end
endmodule
